// *** rtl/dps_pkg.sv ***
package dps_pkg;

  // ****************************************
  // Data widths and timing
  // ****************************************
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOG_DEPTH = 40;
  localparam int UV_ALARM_PCT = 70;
  localparam int UV_TRIP_PCT = 65;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_STALL_FREQ = 8'h04;
  localparam logic [AW-1:0] REG_STALL_TIME = 8'h08;
  localparam logic [AW-1:0] REG_UL_TIME = 8'h0c;
  localparam logic [AW-1:0] REG_MAX_SPEED = 8'h10;
  localparam logic [AW-1:0] REG_DC_NOMINAL = 8'h14;
  localparam logic [AW-1:0] REG_UL_LEVEL = 8'h18;
  localparam logic [AW-1:0] REG_IRQ_STATUS = 8'h1c;
  localparam logic [AW-1:0] REG_IRQ_CLEAR = 8'h20;
  localparam logic [AW-1:0] REG_IRQ_ENABLE = 8'h24;
  localparam logic [AW-1:0] REG_FAULT_LATCH = 8'h28;
  localparam logic [AW-1:0] REG_REMOTE_MASK = 8'h2c;
  localparam logic [AW-1:0] REG_FAULT_CLEAR = 8'h30;
  localparam logic [AW-1:0] REG_LOG_SEL = 8'h34;
  localparam logic [AW-1:0] REG_LOG_DATA = 8'h38;
  localparam logic [AW-1:0] REG_LOG_STATUS = 8'h3c;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_STALL_EN = 0;
  localparam int CTRL_STALL_TRIP = 1;
  localparam int CTRL_UL_RESP_LSB = 2;
  localparam int CTRL_UL_CURVE_LSB = 4;
  localparam int CTRL_RIDE_SEL = 7;
  localparam logic [1:0] UL_RESP_NONE = 2'h0;
  localparam logic [1:0] UL_RESP_ALARM = 2'h1;
  localparam logic [1:0] UL_RESP_TRIP = 2'h2;
  localparam logic [2:0] UL_CURVE_LAST = 3'h4;

  // ****************************************
  // Fault event bits
  // ****************************************
  localparam int NEV = 8;
  localparam int EV_STALL_ALARM = 0;
  localparam int EV_STALL_TRIP = 1;
  localparam int EV_UL_ALARM = 2;
  localparam int EV_UL_TRIP = 3;
  localparam int EV_OVERSPEED = 4;
  localparam int EV_EXT_OVERSPEED = 5;
  localparam int EV_UV_ALARM = 6;
  localparam int EV_UV_TRIP = 7;
  localparam logic [NEV-1:0] ALARM_EVENTS = 8'h45;
  localparam logic [NEV-1:0] TRIP_EVENTS = 8'hba;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [DW-1:0] THRESH_RESET = 16'hffff;
  localparam logic [DW-1:0] NOMINAL_RESET = 16'h0000;
  localparam logic [NEV-1:0] REMOTE_MASK_RESET = 8'h45;

  // ****************************************
  // Underload curves: eighths of level per speed quarter
  // ****************************************
  localparam logic [15:0] UL_CURVE0 = 16'h8888;
  localparam logic [15:0] UL_CURVE1 = 16'h8642;
  localparam logic [15:0] UL_CURVE2 = 16'h8864;
  localparam logic [15:0] UL_CURVE3 = 16'h2468;
  localparam logic [15:0] UL_CURVE4 = 16'h8421;

  function automatic logic below_pct(input logic [DW-1:0] lvl, input logic [DW-1:0] nom, input int pct);
    logic [31:0] a;
    logic [31:0] b;
    a = 32'(lvl) * 32'd100;
    b = 32'(nom) * 32'(pct);
    return a < b;
  endfunction : below_pct

  function automatic logic [DW-1:0] ul_threshold(input logic [DW-1:0] lvl, input logic [2:0] curve,
                                                 input logic [DW-1:0] speed);
    logic [15:0] w;
    logic [3:0] f;
    logic [DW+3:0] p;
    case (curve)
      3'h1: w = UL_CURVE1;
      3'h2: w = UL_CURVE2;
      3'h3: w = UL_CURVE3;
      3'h4: w = UL_CURVE4;
      default: w = UL_CURVE0;
    endcase
    f = w[4*speed[DW-1:DW-2] +: 4];
    p = (DW+4)'(lvl) * (DW+4)'(f);
    return p[DW+2:3];
  endfunction : ul_threshold

endpackage : dps_pkg

// *** rtl/dps_supervisor.sv ***
// Function
// - Stall needs low frequency, torque limit, time.
// - Stall enable and alarm-or-trip selection.
// - Five selectable load curves for underload.
// - Underload after load below curve too long.
// - Underload response: alarm, trip, or none.
// - Trip when speed exceeds maximum speed.
// - Active-low external overspeed input trips.
// - Below 70% nominal: alarm, optional ride-through.
// - Below 65% nominal: undervoltage trip.
// - Slash-named signals are active low.
// - Lockout blocks panel local/remote switching.
// - Remote close request closes main breaker unless open is also requested.
// - Remote open request opens main breaker.
// - Remote clear resets only resettable faults.
// - Ready needs breaker closed, charged, no lockout.
// - Relay outputs: running, alarm, tripped, local.
// - Keep forty newest fault events, drop oldest.
//
// Strobed register access and the placing of the registers were left to the implementer.
module dps_supervisor
  import dps_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int LOG_N = LOG_DEPTH
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Register port
  input wire logic [AW-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_IRQ,
  // Drive control measurements
  input wire logic [DW-1:0] I_OUT_FREQ,
  input wire logic [DW-1:0] I_SPEED,
  input wire logic I_TORQUE_LIMIT,
  input wire logic [DW-1:0] I_LOAD,
  input wire logic [DW-1:0] I_DC_POS,
  input wire logic [DW-1:0] I_DC_NEG,
  input wire logic I_DRIVE_RUNNING,
  input wire logic I_MAIN_BREAKER_CLOSED,
  input wire logic I_DC_CHARGED,
  input wire logic I_LOCKOUT_ACTIVE,
  // Discrete supervisory inputs
  input wire logic I_EXT_OVERSPEED_B,
  input wire logic I_LOCAL_LOCKOUT,
  input wire logic I_PANEL_LOCAL_TOGGLE,
  input wire logic I_REMOTE_BREAKER_CLOSE_REQ,
  input wire logic I_REMOTE_BREAKER_OPEN_REQ,
  input wire logic I_REMOTE_FAULT_CLEAR,
  // Relay and breaker outputs
  output logic O_READY,
  output logic O_RUNNING,
  output logic O_ALARM,
  output logic O_TRIPPED,
  output logic O_LOCAL_MODE,
  output logic O_MAIN_BREAKER_CLOSE,
  output logic O_MAIN_BREAKER_OPEN,
  output logic O_RIDE_THROUGH
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int LW = 6;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (TICK_CYC < 2) begin : g_tick_chk
    $error("TICK_CYC must be at least 2");
  end
  if (LOG_N < 1 || LOG_N > 63) begin : g_log_chk
    $error("LOG_N must lie in 1..63");
  end

  typedef struct packed {
    logic [TW-1:0] tick_cnt;
    logic [7:0] ctrl;
    logic [DW-1:0] stall_freq;
    logic [DW-1:0] stall_time;
    logic [DW-1:0] ul_time;
    logic [DW-1:0] max_speed;
    logic [DW-1:0] dc_nominal;
    logic [DW-1:0] ul_level;
    logic [DW-1:0] stall_cnt;
    logic [DW-1:0] ul_cnt;
    logic [NEV-1:0] cond_prev;
    logic [NEV-1:0] latch;
    logic [NEV-1:0] irq_st;
    logic [NEV-1:0] irq_en;
    logic [NEV-1:0] remote_mask;
    logic local_mode;
    logic [LOG_N-1:0][NEV-1:0] log_mem;
    logic [LW-1:0] log_wp;
    logic [LW-1:0] log_cnt;
    logic [LW-1:0] log_sel;
    logic [31:0] rdata;
    logic irq;
    logic ready;
    logic running;
    logic alarm;
    logic tripped;
    logic br_close;
    logic br_open;
    logic ride;
  } dps_state_t;

  dps_state_t s_q;
  dps_state_t s_d;

  logic tick;
  logic stall_cond;
  logic stall_det;
  logic ul_cond;
  logic ul_det;
  logic uv_alarm;
  logic uv_trip;
  logic [1:0] ul_resp;
  logic [NEV-1:0] cond;
  logic [NEV-1:0] rise;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_d = s_q;
    tick = (s_q.tick_cnt == TW'(TICK_CYC - 1));
    s_d.tick_cnt = tick ? '0 : TW'(s_q.tick_cnt + 1'b1);

    // Stall timer
    stall_cond = (I_OUT_FREQ < s_q.stall_freq) && I_TORQUE_LIMIT;
    if (!stall_cond) begin
      s_d.stall_cnt = '0;
    end else if (tick && s_q.stall_cnt != '1) begin
      s_d.stall_cnt = DW'(s_q.stall_cnt + 1'b1);
    end
    stall_det = stall_cond && (s_q.stall_cnt > s_q.stall_time);

    // Underload timer against the chosen curve
    ul_cond = I_LOAD < ul_threshold(s_q.ul_level, s_q.ctrl[CTRL_UL_CURVE_LSB +: 3], I_SPEED);
    if (!ul_cond) begin
      s_d.ul_cnt = '0;
    end else if (tick && s_q.ul_cnt != '1) begin
      s_d.ul_cnt = DW'(s_q.ul_cnt + 1'b1);
    end
    ul_det = ul_cond && (s_q.ul_cnt > s_q.ul_time);
    ul_resp = s_q.ctrl[CTRL_UL_RESP_LSB +: 2];

    // DC link supervision, either rail
    uv_alarm = below_pct(I_DC_POS, s_q.dc_nominal, UV_ALARM_PCT)
             || below_pct(I_DC_NEG, s_q.dc_nominal, UV_ALARM_PCT);
    uv_trip = below_pct(I_DC_POS, s_q.dc_nominal, UV_TRIP_PCT)
            || below_pct(I_DC_NEG, s_q.dc_nominal, UV_TRIP_PCT);

    cond = '0;
    cond[EV_STALL_ALARM] = stall_det && s_q.ctrl[CTRL_STALL_EN] && !s_q.ctrl[CTRL_STALL_TRIP];
    cond[EV_STALL_TRIP] = stall_det && s_q.ctrl[CTRL_STALL_EN] && s_q.ctrl[CTRL_STALL_TRIP];
    cond[EV_UL_ALARM] = ul_det && (ul_resp == UL_RESP_ALARM);
    cond[EV_UL_TRIP] = ul_det && (ul_resp == UL_RESP_TRIP);
    cond[EV_OVERSPEED] = I_SPEED > s_q.max_speed;
    cond[EV_EXT_OVERSPEED] = !I_EXT_OVERSPEED_B;
    cond[EV_UV_ALARM] = uv_alarm;
    cond[EV_UV_TRIP] = uv_trip;
    rise = cond & ~s_q.cond_prev;
    s_d.cond_prev = cond;

    // Fault latch: clears first, live conditions win
    if (I_REMOTE_FAULT_CLEAR) begin
      s_d.latch = s_d.latch & ~s_q.remote_mask;
    end
    if (I_WR && I_ADDR == REG_FAULT_CLEAR) begin
      s_d.latch = s_d.latch & ~I_WDATA[NEV-1:0];
    end
    s_d.latch = s_d.latch | cond;

    // Interrupt status, set wins over clear
    if (I_WR && I_ADDR == REG_IRQ_CLEAR) begin
      s_d.irq_st = s_q.irq_st & ~I_WDATA[NEV-1:0];
    end
    s_d.irq_st = s_d.irq_st | rise;

    // Fault history ring
    if (|rise) begin
      s_d.log_mem[s_q.log_wp] = rise;
      s_d.log_wp = (s_q.log_wp == LW'(LOG_N - 1)) ? '0 : LW'(s_q.log_wp + 1'b1);
      if (s_q.log_cnt != LW'(LOG_N)) begin
        s_d.log_cnt = LW'(s_q.log_cnt + 1'b1);
      end
    end

    // Local/remote selection from the panel
    if (I_PANEL_LOCAL_TOGGLE && !I_LOCAL_LOCKOUT) begin
      s_d.local_mode = ~s_q.local_mode;
    end

    // Register writes
    if (I_WR) begin
      case (I_ADDR)
        REG_CTRL: s_d.ctrl = I_WDATA[7:0];
        REG_STALL_FREQ: s_d.stall_freq = I_WDATA[DW-1:0];
        REG_STALL_TIME: s_d.stall_time = I_WDATA[DW-1:0];
        REG_UL_TIME: s_d.ul_time = I_WDATA[DW-1:0];
        REG_MAX_SPEED: s_d.max_speed = I_WDATA[DW-1:0];
        REG_DC_NOMINAL: s_d.dc_nominal = I_WDATA[DW-1:0];
        REG_UL_LEVEL: s_d.ul_level = I_WDATA[DW-1:0];
        REG_IRQ_ENABLE: s_d.irq_en = I_WDATA[NEV-1:0];
        REG_REMOTE_MASK: s_d.remote_mask = I_WDATA[NEV-1:0];
        REG_LOG_SEL: s_d.log_sel = I_WDATA[LW-1:0];
        default: ;
      endcase
      if (I_ADDR == REG_CTRL && I_WDATA[CTRL_UL_CURVE_LSB +: 3] > UL_CURVE_LAST) begin
        s_d.ctrl[CTRL_UL_CURVE_LSB +: 3] = s_q.ctrl[CTRL_UL_CURVE_LSB +: 3];
      end
    end

    // Register reads, data valid next cycle only
    s_d.rdata = '0;
    if (I_RD) begin
      case (I_ADDR)
        REG_CTRL: s_d.rdata = 32'(s_q.ctrl);
        REG_STALL_FREQ: s_d.rdata = 32'(s_q.stall_freq);
        REG_STALL_TIME: s_d.rdata = 32'(s_q.stall_time);
        REG_UL_TIME: s_d.rdata = 32'(s_q.ul_time);
        REG_MAX_SPEED: s_d.rdata = 32'(s_q.max_speed);
        REG_DC_NOMINAL: s_d.rdata = 32'(s_q.dc_nominal);
        REG_UL_LEVEL: s_d.rdata = 32'(s_q.ul_level);
        REG_IRQ_STATUS: s_d.rdata = 32'(s_q.irq_st);
        REG_IRQ_ENABLE: s_d.rdata = 32'(s_q.irq_en);
        REG_FAULT_LATCH: s_d.rdata = 32'(s_q.latch);
        REG_REMOTE_MASK: s_d.rdata = 32'(s_q.remote_mask);
        REG_LOG_SEL: s_d.rdata = 32'(s_q.log_sel);
        REG_LOG_DATA: s_d.rdata = (s_q.log_sel < LW'(LOG_N)) ? 32'(s_q.log_mem[s_q.log_sel]) : '0;
        REG_LOG_STATUS: s_d.rdata = {16'h0000, 2'h0, s_q.log_cnt, 2'h0, s_q.log_wp};
        default: s_d.rdata = '0;
      endcase
    end

    // Relay outputs
    s_d.irq = |(s_d.irq_st & s_d.irq_en);
    s_d.ready = I_MAIN_BREAKER_CLOSED && I_DC_CHARGED && !I_LOCKOUT_ACTIVE;
    s_d.running = I_DRIVE_RUNNING;
    s_d.alarm = |(s_d.latch & ALARM_EVENTS);
    s_d.tripped = |(s_d.latch & TRIP_EVENTS);
    s_d.br_open = I_REMOTE_BREAKER_OPEN_REQ;
    s_d.br_close = I_REMOTE_BREAKER_CLOSE_REQ && !I_REMOTE_BREAKER_OPEN_REQ;
    s_d.ride = uv_alarm && s_q.ctrl[CTRL_RIDE_SEL];
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.stall_freq <= '0;
      s_q.stall_time <= THRESH_RESET;
      s_q.ul_time <= THRESH_RESET;
      s_q.max_speed <= THRESH_RESET;
      s_q.dc_nominal <= NOMINAL_RESET;
      s_q.remote_mask <= REMOTE_MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_RDATA = s_q.rdata;
  assign O_IRQ = s_q.irq;
  assign O_READY = s_q.ready;
  assign O_RUNNING = s_q.running;
  assign O_ALARM = s_q.alarm;
  assign O_TRIPPED = s_q.tripped;
  assign O_LOCAL_MODE = s_q.local_mode;
  assign O_MAIN_BREAKER_CLOSE = s_q.br_close;
  assign O_MAIN_BREAKER_OPEN = s_q.br_open;
  assign O_RIDE_THROUGH = s_q.ride;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_B);

  stall_cause_a:
    assert property ($rose(s_q.latch[EV_STALL_TRIP]) |->
      $past(I_TORQUE_LIMIT && (I_OUT_FREQ < s_q.stall_freq) && s_q.stall_cnt > s_q.stall_time))
    else $error("stall trip without its three conditions");

  stall_restart_a:
    assert property (!I_TORQUE_LIMIT |=> s_q.stall_cnt == '0)
    else $error("stall timer not restarted");

  ul_resp_a:
    assert property (s_q.ctrl[CTRL_UL_RESP_LSB +: 2] == UL_RESP_NONE |=>
      !s_q.cond_prev[EV_UL_ALARM] && !s_q.cond_prev[EV_UL_TRIP])
    else $error("underload reported with no reaction selected");

  overspeed_a:
    assert property ((I_SPEED > s_q.max_speed) |=> O_TRIPPED)
    else $error("overspeed did not trip");

  ext_overspeed_a:
    assert property (!I_EXT_OVERSPEED_B |=> O_TRIPPED ##0 s_q.latch[EV_EXT_OVERSPEED])
    else $error("external overspeed did not trip");

  uv_alarm_a:
    assert property (below_pct(I_DC_POS, s_q.dc_nominal, UV_ALARM_PCT) |=> O_ALARM)
    else $error("undervoltage alarm missing");

  uv_trip_a:
    assert property (below_pct(I_DC_NEG, s_q.dc_nominal, UV_TRIP_PCT) |=> O_TRIPPED)
    else $error("undervoltage trip missing");

  local_lock_a:
    assert property (I_LOCAL_LOCKOUT |=> $stable(O_LOCAL_MODE))
    else $error("local mode changed under lockout");

  breaker_close_a:
    assert property (I_REMOTE_BREAKER_CLOSE_REQ && !I_REMOTE_BREAKER_OPEN_REQ |=> O_MAIN_BREAKER_CLOSE)
    else $error("close request not passed on");

  breaker_open_a:
    assert property (I_REMOTE_BREAKER_OPEN_REQ |=> O_MAIN_BREAKER_OPEN && !O_MAIN_BREAKER_CLOSE)
    else $error("open request not passed on");

  remote_clear_a:
    assert property (I_REMOTE_FAULT_CLEAR && !(I_WR && I_ADDR == REG_FAULT_CLEAR)
      |=> ($past(s_q.latch & ~s_q.remote_mask) & ~s_q.latch) == '0)
    else $error("remote clear dropped a latched fault");

  ready_a:
    assert property (O_READY |-> $past(I_MAIN_BREAKER_CLOSED && I_DC_CHARGED && !I_LOCKOUT_ACTIVE))
    else $error("ready without breaker, charge and no lockout");

  log_count_a:
    assert property (|(cond & ~s_q.cond_prev) |=>
      s_q.log_cnt == (($past(s_q.log_cnt) == LW'(LOG_N)) ? LW'(LOG_N) : LW'($past(s_q.log_cnt) + 1'b1)))
    else $error("fault history count wrong");

  stall_off_a:
    assert property (!s_q.ctrl[CTRL_STALL_EN] |=> !s_q.cond_prev[EV_STALL_ALARM] && !s_q.cond_prev[EV_STALL_TRIP])
    else $error("stall reported while disabled");

  stall_kind_a:
    assert property (s_q.ctrl[CTRL_STALL_TRIP] |=> !s_q.cond_prev[EV_STALL_ALARM])
    else $error("stall alarm raised with trip selected");

  ul_time_a:
    assert property ($rose(s_q.cond_prev[EV_UL_ALARM] || s_q.cond_prev[EV_UL_TRIP]) |->
      $past(s_q.ul_cnt > s_q.ul_time))
    else $error("underload declared before its time");

  ul_restart_a:
    assert property (I_LOAD >= ul_threshold(s_q.ul_level, s_q.ctrl[CTRL_UL_CURVE_LSB +: 3], I_SPEED)
      |=> s_q.ul_cnt == '0)
    else $error("underload timer not restarted");

  curve_keep_a:
    assert property (s_q.ctrl[CTRL_UL_CURVE_LSB +: 3] <= UL_CURVE_LAST)
    else $error("underload curve outside the five");

  relay_level_a:
    assert property ((O_ALARM == |(s_q.latch & ALARM_EVENTS)) && (O_TRIPPED == |(s_q.latch & TRIP_EVENTS)))
    else $error("alarm or trip relay disagrees with latch");

  running_a:
    assert property ((I_DRIVE_RUNNING |=> O_RUNNING) and (!I_DRIVE_RUNNING |=> !O_RUNNING))
    else $error("running relay does not follow drive");

  ride_sel_a:
    assert property (!s_q.ctrl[CTRL_RIDE_SEL] |=> !O_RIDE_THROUGH)
    else $error("ride-through without selection");

  log_slot_a:
    assert property (|(cond & ~s_q.cond_prev) |=>
      s_q.log_mem[$past(s_q.log_wp)] == $past(cond & ~s_q.cond_prev))
    else $error("fault history entry wrong");

endmodule : dps_supervisor

// *** verif/dps_partner.sv ***
module dps_partner (
  // Clock and bench commands
  input wire logic i_clk,
  input wire logic i_ovs,
  input wire logic i_close,
  input wire logic i_open,
  input wire logic i_clear,
  input wire logic i_lock,
  // Discrete lines to the drive
  output logic o_ext_overspeed_b,
  output logic o_close_req,
  output logic o_open_req,
  output logic o_fault_clear,
  output logic o_local_lockout
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Supervisory controller lines
  // ****************************************
  // Relay contact opens on overspeed
  always @(posedge i_clk) begin
    o_ext_overspeed_b <= !i_ovs;
    o_close_req <= i_close;
    o_open_req <= i_open;
    o_fault_clear <= i_clear;
    o_local_lockout <= i_lock;
  end
endmodule : dps_partner

// *** verif/tb_top.sv ***
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin $display("BAD %s exp %0h got %0h", n, e, g); mismatches++; end end

module tb_top
  import dps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  int mismatches = 0;
  int tests_run = 0;
  logic clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, tq = 1'b0, tog = 1'b0;
  logic run = 1'b0, brk = 1'b0, chg = 1'b0, lko = 1'b0;
  logic ovs = 1'b0, cls = 1'b0, opn = 1'b0, clr = 1'b0, lck = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [DW-1:0] freq = 16'hffff, speed = 16'h0, load = 16'hffff, dcp = 16'd1000, dcn = 16'd1000;
  logic [31:0] rdata;
  logic irq, rdy, runo, alm, trp, loc, bc, bo, rt, ext_b, creq, oreq, fclr, llk;
  logic [31:0] sc [4] = '{32'h3, 32'h1, 32'h0, 32'h3};
  logic [15:0] sf [4] = '{16'd50, 16'd50, 16'd50, 16'd100};
  logic [31:0] se [4] = '{32'h2, 32'h1, 32'h0, 32'h0};
  logic [15:0] crv [5] = '{UL_CURVE0, UL_CURVE1, UL_CURVE2, UL_CURVE3, UL_CURVE4};

  always #4 clk = ~clk;

  dps_supervisor #(.TICK_CYC(4), .LOG_N(LOG_DEPTH)) i_dps_supervisor (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
    .O_RDATA(rdata), .O_IRQ(irq), .I_OUT_FREQ(freq), .I_SPEED(speed), .I_TORQUE_LIMIT(tq),
    .I_LOAD(load), .I_DC_POS(dcp), .I_DC_NEG(dcn), .I_DRIVE_RUNNING(run),
    .I_MAIN_BREAKER_CLOSED(brk), .I_DC_CHARGED(chg), .I_LOCKOUT_ACTIVE(lko),
    .I_EXT_OVERSPEED_B(ext_b), .I_LOCAL_LOCKOUT(llk), .I_PANEL_LOCAL_TOGGLE(tog),
    .I_REMOTE_BREAKER_CLOSE_REQ(creq), .I_REMOTE_BREAKER_OPEN_REQ(oreq), .I_REMOTE_FAULT_CLEAR(fclr),
    .O_READY(rdy), .O_RUNNING(runo), .O_ALARM(alm), .O_TRIPPED(trp), .O_LOCAL_MODE(loc),
    .O_MAIN_BREAKER_CLOSE(bc), .O_MAIN_BREAKER_OPEN(bo), .O_RIDE_THROUGH(rt)
  );

  dps_partner i_dps_partner (
    .i_clk(clk), .i_ovs(ovs), .i_close(cls), .i_open(opn), .i_clear(clr), .i_lock(lck),
    .o_ext_overspeed_b(ext_b), .o_close_req(creq), .o_open_req(oreq), .o_fault_clear(fclr),
    .o_local_lockout(llk)
  );

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Look at outputs away from the edge
  task automatic mid;
    @(negedge clk);
  endtask : mid

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic chk(input logic [AW-1:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    rd(a, d);
    `CHK(n, e, d)
  endtask : chk

  // Let conditions drop before clearing latches
  task automatic clr_all;
    cyc(3);
    wr(REG_IRQ_CLEAR, 32'hff);
    wr(REG_FAULT_CLEAR, 32'hff);
  endtask : clr_all

  task automatic toggle;
    @(posedge clk) tog <= 1'b1;
    @(posedge clk) tog <= 1'b0;
    cyc(2);
    mid();
  endtask : toggle

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  // Underload threshold: level times curve eighths
  function automatic int ul_thr(input int lvl, input int c, input logic [1:0] q);
    return (lvl * int'(crv[c][4*q +: 4])) >> 3;
  endfunction : ul_thr

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    int t;
    logic [1:0] q;
    void'($urandom(67586));
    cyc(12);
    rst_b <= 1'b1;
    chk(REG_CTRL, 32'h0, "ctrl");
    chk(REG_REMOTE_MASK, 32'h45, "rmask");
    chk(8'hfc, 32'h0, "unmapped");
    wr(REG_CTRL, 32'h74);
    chk(REG_CTRL, 32'h4, "bad curve");
    wr(REG_CTRL, 32'h0);
    done("reset");
    wr(REG_IRQ_ENABLE, 32'h20);
    @(posedge clk) ovs <= 1'b1;
    cyc(3);
    mid();
    `CHK("trip", 1'b1, trp)
    `CHK("irq", 1'b1, irq)
    chk(REG_FAULT_LATCH, 32'h20, "latch");
    @(posedge clk) ovs <= 1'b0;
    clr_all();
    mid();
    `CHK("irq off", 1'b0, irq)
    `CHK("trip off", 1'b0, trp)
    wr(REG_IRQ_ENABLE, 32'h0);
    @(posedge clk) ovs <= 1'b1;
    cyc(3);
    chk(REG_IRQ_STATUS, 32'h20, "status");
    `CHK("masked", 1'b0, irq)
    @(posedge clk) ovs <= 1'b0;
    clr_all();
    done("ext overspeed");
    v = 32'($urandom_range(16'hfffe, 16'h100));
    wr(REG_MAX_SPEED, v);
    @(posedge clk) speed <= v[15:0];
    cyc(3);
    chk(REG_FAULT_LATCH, 32'h0, "equal");
    @(posedge clk) speed <= v[15:0] + 16'h1;
    cyc(3);
    chk(REG_FAULT_LATCH, 32'h10, "over");
    @(posedge clk) speed <= 16'h0;
    wr(REG_MAX_SPEED, 32'hffff);
    clr_all();
    done("overspeed");
    wr(REG_DC_NOMINAL, 32'd1000);
    wr(REG_CTRL, 32'h80);
    @(posedge clk) dcn <= 16'd699;
    @(posedge clk) dcp <= 16'd650;
    cyc(3);
    mid();
    `CHK("ride", 1'b1, rt)
    `CHK("alarm", 1'b1, alm)
    chk(REG_FAULT_LATCH, 32'h40, "uv alarm");
    @(posedge clk) dcp <= 16'd649;
    cyc(3);
    chk(REG_FAULT_LATCH, 32'hc0, "uv trip");
    @(posedge clk) dcp <= 16'd1000;
    @(posedge clk) dcn <= 16'd1000;
    cyc(3);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    cyc(3);
    chk(REG_FAULT_LATCH, 32'h80, "remote clr");
    wr(REG_CTRL, 32'h0);
    clr_all();
    done("undervoltage");
    wr(REG_STALL_FREQ, 32'd100);
    wr(REG_STALL_TIME, 32'd2);
    wr(REG_CTRL, 32'h3);
    @(posedge clk) freq <= 16'd50;
    @(posedge clk) tq <= 1'b1;
    cyc(6);
    @(posedge clk) tq <= 1'b0;
    @(posedge clk) tq <= 1'b1;
    cyc(6);
    @(posedge clk) tq <= 1'b0;
    chk(REG_FAULT_LATCH, 32'h0, "restart");
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, sc[i]);
      @(posedge clk) freq <= sf[i];
      @(posedge clk) tq <= 1'b1;
      cyc(30);
      chk(REG_FAULT_LATCH, se[i], "stall");
      @(posedge clk) tq <= 1'b0;
      clr_all();
    end
    @(posedge clk) freq <= 16'hffff;
    done("stall");
    wr(REG_UL_LEVEL, 32'd800);
    wr(REG_UL_TIME, 32'd1);
    for (int c = 0; c < 5; c++) begin
      q = 2'($urandom_range(3));
      t = ul_thr(800, c, q);
      wr(REG_CTRL, {25'h0, 3'(c), 2'(c % 3), 2'h0});
      @(posedge clk) speed <= {q, 14'h0123};
      @(posedge clk) load <= 16'(t);
      cyc(30);
      chk(REG_FAULT_LATCH, 32'h0, "ul at curve");
      @(posedge clk) load <= 16'(t - 1);
      cyc(30);
      chk(REG_FAULT_LATCH, 32'((c % 3) * 4), "ul below");
      @(posedge clk) load <= 16'hffff;
      clr_all();
    end
    @(posedge clk) speed <= 16'h0;
    done("underload");
    @(posedge clk) cls <= 1'b1;
    cyc(3);
    mid();
    `CHK("close", 1'b1, bc)
    `CHK("no open", 1'b0, bo)
    @(posedge clk) opn <= 1'b1;
    cyc(3);
    mid();
    `CHK("open", 1'b1, bo)
    `CHK("open wins", 1'b0, bc)
    @(posedge clk) cls <= 1'b0;
    @(posedge clk) opn <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) {brk, chg, lko, run} <= {i[2:0], ~i[0]};
      cyc(2);
      mid();
      `CHK("ready", 1'(i == 6), rdy)
      `CHK("running", ~i[0], runo)
    end
    toggle();
    `CHK("local", 1'b1, loc)
    @(posedge clk) lck <= 1'b1;
    toggle();
    `CHK("locked", 1'b1, loc)
    @(posedge clk) lck <= 1'b0;
    toggle();
    `CHK("remote", 1'b0, loc)
    done("discretes");
    for (int i = 0; i < 42; i++) begin
      @(posedge clk) ovs <= 1'b1;
      cyc(3);
      @(posedge clk) ovs <= 1'b0;
      cyc(3);
    end
    rd(REG_LOG_STATUS, v);
    `CHK("log count", 32'(LOG_DEPTH), 32'(v[13:8]))
    wr(REG_LOG_SEL, 32'(v[5:0]));
    chk(REG_LOG_DATA, 32'h20, "oldest");
    wr(REG_LOG_SEL, 32'((int'(v[5:0]) + LOG_DEPTH - 1) % LOG_DEPTH));
    chk(REG_LOG_DATA, 32'h20, "newest");
    wr(REG_LOG_SEL, 32'(LOG_DEPTH));
    chk(REG_LOG_DATA, 32'h0, "beyond");
    done("log");
    wrap_up();
  end
endmodule : tb_top
